// [core/rsp_reset_strap_pin_function.sv]
// Top: strap capture, shared-pin roles, role select and reference roles
`timescale 1ns/1ps
module rsp_reset_strap_pin_function #(
	parameter int NUM_CC = 2,
	parameter int NUM_DIFF = 5,
	parameter int NUM_LOS = 4
) (
	// System clock (the oscillator input) and reset
	input wire logic clk,
	input wire logic srst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Shared strap / loss pins and the role-select pin
	input wire logic oscFreqStrap0,
	input wire logic oscFreqStrap1,
	input wire logic oscFreqStrap2,
	input wire logic rateFamilyStrap,
	input wire logic roleSelectPin,
	// Strap results and role
	output logic [2:0] oscFreqSel,
	output logic rateFamilyBit,
	output logic isMaster,
	// Reference roles
	output logic [NUM_CC-1:0] ccFramePulseMode,
	output logic [NUM_CC-1:0] cc400Present,
	output logic [NUM_DIFF-1:0] diffSyncMode,
	output logic [NUM_DIFF*2-1:0] diffSyncRate,
	output logic [NUM_DIFF*3-1:0] diffSyncPartner,
	output logic [NUM_DIFF-1:0] pairError,
	output logic [NUM_CC+NUM_DIFF-1:0] refDisqualified
);
	import rsp_pkg::*;

	localparam int NUM_REFS = NUM_CC + NUM_DIFF;

	// Index fields are three bits wide and the map holds four loss lines
	if (NUM_REFS > 7 || NUM_REFS < 1 || NUM_LOS != 4 || NUM_CC > 2 ||
			NUM_DIFF > 5) begin : gBadParams
		$error("rsp: reference or loss count outside supported range");
	end

	// Register fields must fit one 32-bit word at their chosen positions
	if (RSP_MODE_RATE_LSB + NUM_DIFF*2 > 32 ||
			RSP_QUAL_PAIRERR_LSB + NUM_DIFF > 32) begin : gBadFields
		$error("rsp: register fields overflow the data word");
	end

	logic rateStrap;
	logic strapHeld;
	logic roleCtrlBit;
	logic [15:0] losMap;
	logic [NUM_LOS-1:0] losLevel;
	logic [NUM_LOS-1:0] losEnable;
	logic [NUM_LOS*3-1:0] losTarget;
	logic [NUM_REFS-1:0] refNotClock;
	logic [NUM_DIFF-1:0] next_pairError;
	logic setupPhase;
	logic writeAccess;
	logic addrMapped;
	logic [31:0] next_prdata;
	logic wrConfig;
	logic wrLosMap;
	logic wrRefMode;
	logic wrPair;

	// ==============================================================
	// Strap capture
	// The whole block is clocked by the oscillator clock, clk
	rsp_strap_capture uStrap (
		.clk(clk),
		.srst(srst),
		.freqPins({oscFreqStrap2, oscFreqStrap1, oscFreqStrap0}),
		.ratePin(rateFamilyStrap),
		.oscFreqSel(oscFreqSel),
		.rateStrap(rateStrap),
		.strapHeld(strapHeld)
	);

	// ==============================================================
	// Shared pins as loss lines
	// Same pins, new meaning once the straps are frozen
	// While reset holds these levels are strap codes; the qualifiers
	// ignore them until strapHeld rises, so a high strap is no loss
	assign losLevel = {rateFamilyStrap, oscFreqStrap2, oscFreqStrap1,
		oscFreqStrap0};

	// Unpack loss-line assignment fields
	genvar gl;
	for (gl = 0; gl < NUM_LOS; gl++) begin : gLosMap
		assign losEnable[gl] =
			losMap[gl*RSP_LOSMAP_FIELD_W + RSP_LOSMAP_EN_POS];
		assign losTarget[gl*3 +: 3] = losMap[gl*RSP_LOSMAP_FIELD_W +: 3];
	end

	// One disqualifier per reference input
	// Each instance compares every line target with its own index,
	// so several lines may point at one reference
	genvar gr;
	for (gr = 0; gr < NUM_REFS; gr++) begin : gQual
		rsp_ref_qualifier #(
			.REF_INDEX(gr),
			.NUM_LOS(NUM_LOS)
		) uQual (
			.clk(clk),
			.srst(srst),
			.losLive(strapHeld),
			.losLevel(losLevel),
			.losEnable(losEnable),
			.losTarget(losTarget),
			.disqualified(refDisqualified[gr])
		);
	end

	// ==============================================================
	// Configuration registers
	// Rate-family bit tracks the strap through reset, software owns it after
	always_ff @(posedge clk) begin
		if (srst) begin
			rateFamilyBit <= rateFamilyStrap;
		end else if (wrConfig) begin
			rateFamilyBit <= pwdata[RSP_CFG_RATE_FAMILY_POS];
		end
	end

	// Role control bit
	always_ff @(posedge clk) begin
		if (srst) begin
			roleCtrlBit <= RSP_ROLE_CTRL_RST;
		end else if (wrConfig) begin
			roleCtrlBit <= pwdata[RSP_CFG_ROLE_CTRL_POS];
		end
	end

	// Loss-line assignment map
	// A field with its enable clear is parked; its target is kept so
	// software can arm a line without rewriting the index
	always_ff @(posedge clk) begin
		if (srst) begin
			losMap <= RSP_LOS_MAP_RST;
		end else if (wrLosMap) begin
			losMap <= pwdata[15:0];
		end
	end

	// Reference roles: composite clock or frame pulse, clock or sync
	// Software may change a role at any time; the pairing check below
	// judges every partner again on the next edge
	always_ff @(posedge clk) begin
		if (srst) begin
			ccFramePulseMode <= RSP_CC_FP_RST[NUM_CC-1:0];
			cc400Present <= RSP_CC_400_RST[NUM_CC-1:0];
			diffSyncMode <= RSP_SYNC_MODE_RST[NUM_DIFF-1:0];
			diffSyncRate <= RSP_SYNC_RATE_RST[NUM_DIFF*2-1:0];
		end else if (wrRefMode) begin
			ccFramePulseMode <= pwdata[RSP_MODE_CC_FP_LSB +: NUM_CC];
			cc400Present <= pwdata[RSP_MODE_CC_400_LSB +: NUM_CC];
			diffSyncMode <= pwdata[RSP_MODE_SYNC_LSB +: NUM_DIFF];
			diffSyncRate <= pwdata[RSP_MODE_RATE_LSB +: NUM_DIFF*2];
		end
	end

	// Partner clock index for each differential reference
	always_ff @(posedge clk) begin
		if (srst) begin
			diffSyncPartner <= RSP_PAIR_RST[NUM_DIFF*3-1:0];
		end else if (wrPair) begin
			diffSyncPartner <= pwdata[NUM_DIFF*3-1:0];
		end
	end

	// ==============================================================
	// Role selection
	// Control bit inverts the pin's sense; pin high alone means master
	// The pin is taken as already synchronous and is not debounced, so
	// the board must hold it steady while the role matters
	always_ff @(posedge clk) begin
		if (srst) begin
			isMaster <= 1'b0;
		end else begin
			isMaster <= roleSelectPin ^ roleCtrlBit;
		end
	end

	// ==============================================================
	// Sync pairing check
	// A partner must be another input that is itself running as a clock
	// Only the index is judged here; whether the partner really carries
	// a clock is left to the reference monitors outside this block
	assign refNotClock = {diffSyncMode, ccFramePulseMode};

	genvar gp;
	for (gp = 0; gp < NUM_DIFF; gp++) begin : gPair
		localparam logic [2:0] SELF = 3'(NUM_CC + gp);
		logic [2:0] partner;
		logic pairBad;
		assign partner = diffSyncPartner[gp*3 +: 3];
		always_comb begin
			pairBad = 1'b0;
			if (diffSyncMode[gp]) begin
				if (partner == SELF || 32'(partner) >= NUM_REFS) begin
					pairBad = 1'b1;
				end else if (refNotClock[partner]) begin
					pairBad = 1'b1;
				end
			end
		end
		// Each lane owns its verdict bit, so no vector has two writers
		assign next_pairError[gp] = pairBad;
	end

	// Registered so the pairing verdict is glitch-free
	always_ff @(posedge clk) begin
		if (srst) begin
			pairError <= '0;
		end else begin
			pairError <= next_pairError;
		end
	end

	// ==============================================================
	// APB slave
	// Zero wait states: read data is fetched in the setup cycle
	// Fetching at setup keeps prdata a flop output; the cost is that a
	// status read is a snapshot taken one cycle before the access edge
	assign setupPhase = psel && !penable;
	assign writeAccess = psel && penable && pwrite;
	assign pready = 1'b1;
	assign addrMapped = (paddr == RSP_ADDR_STRAP) ||
		(paddr == RSP_ADDR_CONFIG) || (paddr == RSP_ADDR_LOS_MAP) ||
		(paddr == RSP_ADDR_REF_MODE) || (paddr == RSP_ADDR_PAIR) ||
		(paddr == RSP_ADDR_QUAL);
	assign pslverr = psel && penable && !addrMapped;

	// Per-register write strobes, valid only at the access edge
	assign wrConfig = writeAccess && (paddr == RSP_ADDR_CONFIG);
	assign wrLosMap = writeAccess && (paddr == RSP_ADDR_LOS_MAP);
	assign wrRefMode = writeAccess && (paddr == RSP_ADDR_REF_MODE);
	assign wrPair = writeAccess && (paddr == RSP_ADDR_PAIR);

	// Read multiplexer; unmapped and reserved bits read as zero
	always_comb begin
		next_prdata = 32'h0000_0000;
		case (paddr)
			RSP_ADDR_STRAP: begin
				next_prdata[RSP_STRAP_FREQ_LSB +: 3] = oscFreqSel;
				next_prdata[RSP_STRAP_RATE_POS] = rateStrap;
				next_prdata[RSP_STRAP_ROLE_PIN_POS] = roleSelectPin;
				next_prdata[RSP_STRAP_HELD_POS] = strapHeld;
			end
			RSP_ADDR_CONFIG: begin
				next_prdata[RSP_CFG_ROLE_CTRL_POS] = roleCtrlBit;
				next_prdata[RSP_CFG_RATE_FAMILY_POS] = rateFamilyBit;
			end
			RSP_ADDR_LOS_MAP: begin
				next_prdata[15:0] = losMap;
			end
			RSP_ADDR_REF_MODE: begin
				next_prdata[RSP_MODE_CC_FP_LSB +: NUM_CC] = ccFramePulseMode;
				next_prdata[RSP_MODE_CC_400_LSB +: NUM_CC] = cc400Present;
				next_prdata[RSP_MODE_SYNC_LSB +: NUM_DIFF] = diffSyncMode;
				next_prdata[RSP_MODE_RATE_LSB +: NUM_DIFF*2] = diffSyncRate;
			end
			RSP_ADDR_PAIR: begin
				next_prdata[NUM_DIFF*3-1:0] = diffSyncPartner;
			end
			RSP_ADDR_QUAL: begin
				next_prdata[RSP_QUAL_DISQ_LSB +: NUM_REFS] = refDisqualified;
				next_prdata[RSP_QUAL_MASTER_POS] = isMaster;
				next_prdata[RSP_QUAL_LOS_LSB +: NUM_LOS] =
					strapHeld ? losLevel : '0;
				next_prdata[RSP_QUAL_PAIRERR_LSB +: NUM_DIFF] = pairError;
			end
			default: next_prdata = 32'h0000_0000;
		endcase
	end

	// Read data register, loaded at the setup edge, stable in access
	always_ff @(posedge clk) begin
		if (srst) begin
			prdata <= 32'h0000_0000;
		end else if (setupPhase && !pwrite) begin
			prdata <= next_prdata;
		end
	end

endmodule : rsp_reset_strap_pin_function

// [core/rsp_pkg.sv]
// Package: register map, field layout and reset values of the strap block
package rsp_pkg;

	// ==============================================================
	// Register byte offsets on the APB
	localparam logic [7:0] RSP_ADDR_STRAP = 8'h00;
	localparam logic [7:0] RSP_ADDR_CONFIG = 8'h04;
	localparam logic [7:0] RSP_ADDR_LOS_MAP = 8'h08;
	localparam logic [7:0] RSP_ADDR_REF_MODE = 8'h0C;
	localparam logic [7:0] RSP_ADDR_PAIR = 8'h10;
	localparam logic [7:0] RSP_ADDR_QUAL = 8'h14;

	// ==============================================================
	// Field positions
	localparam int RSP_STRAP_FREQ_LSB = 0;
	localparam int RSP_STRAP_RATE_POS = 3;
	localparam int RSP_STRAP_ROLE_PIN_POS = 4;
	localparam int RSP_STRAP_HELD_POS = 5;
	localparam int RSP_CFG_ROLE_CTRL_POS = 0;
	localparam int RSP_CFG_RATE_FAMILY_POS = 2;
	localparam int RSP_LOSMAP_FIELD_W = 4;
	localparam int RSP_LOSMAP_EN_POS = 3;
	localparam int RSP_MODE_CC_FP_LSB = 0;
	localparam int RSP_MODE_CC_400_LSB = 2;
	localparam int RSP_MODE_SYNC_LSB = 4;
	localparam int RSP_MODE_RATE_LSB = 12;
	localparam int RSP_PAIR_FIELD_W = 3;
	localparam int RSP_QUAL_DISQ_LSB = 0;
	localparam int RSP_QUAL_MASTER_POS = 8;
	localparam int RSP_QUAL_LOS_LSB = 12;
	localparam int RSP_QUAL_PAIRERR_LSB = 16;

	// ==============================================================
	// Reset values
	localparam logic [15:0] RSP_LOS_MAP_RST = 16'h0000;
	localparam logic RSP_ROLE_CTRL_RST = 1'b0;
	localparam logic [1:0] RSP_CC_FP_RST = 2'h0;
	localparam logic [1:0] RSP_CC_400_RST = 2'h0;
	localparam logic [4:0] RSP_SYNC_MODE_RST = 5'h00;
	localparam logic [9:0] RSP_SYNC_RATE_RST = 10'h000;
	localparam logic [14:0] RSP_PAIR_RST = 15'h0000;

	// Sync pulse rates of a differential reference in sync role
	typedef enum logic [1:0] {
		RSP_SYNC_2K = 2'b00,
		RSP_SYNC_4K = 2'b01,
		RSP_SYNC_8K = 2'b10,
		RSP_SYNC_1PPS = 2'b11
	} rsp_sync_rate_t;

	// Strap capture phases
	typedef enum logic [0:0] {
		RSP_ST_CAPTURE = 1'b0,
		RSP_ST_HOLD = 1'b1
	} rsp_strap_state_t;

endpackage : rsp_pkg

// [core/rsp_strap_capture.sv]
// Strap latch: samples the shared pins during reset and freezes them
`timescale 1ns/1ps
module rsp_strap_capture (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Shared strap pins
	input wire logic [2:0] freqPins,
	input wire logic ratePin,
	// Captured values
	output logic [2:0] oscFreqSel,
	output logic rateStrap,
	output logic strapHeld
);
	import rsp_pkg::*;

	rsp_strap_state_t state;

	// ==============================================================
	// Phase: capture while reset is high, hold from its release on
	always_ff @(posedge clk) begin
		if (srst) begin
			state <= RSP_ST_CAPTURE;
		end else begin
			case (state)
				RSP_ST_CAPTURE: state <= RSP_ST_HOLD;
				RSP_ST_HOLD: state <= RSP_ST_HOLD;
				default: state <= RSP_ST_CAPTURE;
			endcase
		end
	end

	// Straps follow the pins only during reset; later pin activity is LOS
	always_ff @(posedge clk) begin
		if (srst) begin
			oscFreqSel <= freqPins;
			rateStrap <= ratePin;
		end
	end

	// Flag telling the rest of the block the pins now carry LOS
	always_ff @(posedge clk) begin
		if (srst) begin
			strapHeld <= 1'b0;
		end else begin
			strapHeld <= (state == RSP_ST_HOLD) || (state == RSP_ST_CAPTURE);
		end
	end

endmodule : rsp_strap_capture

// [core/rsp_ref_qualifier.sv]
// Per-reference disqualifier driven by the assignable loss-of-signal lines
`timescale 1ns/1ps
module rsp_ref_qualifier #(
	parameter int REF_INDEX = 0,
	parameter int NUM_LOS = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic srst,
	// Loss lines and their assignment
	input wire logic losLive,
	input wire logic [NUM_LOS-1:0] losLevel,
	input wire logic [NUM_LOS-1:0] losEnable,
	input wire logic [NUM_LOS*3-1:0] losTarget,
	// Result
	output logic disqualified
);
	import rsp_pkg::*;

	localparam logic [2:0] MY_INDEX = 3'(REF_INDEX);

	logic hit;

	// Any enabled loss line aimed at this reference and asserted
	always_comb begin
		hit = 1'b0;
		for (int k = 0; k < NUM_LOS; k++) begin
			if (losEnable[k] && losLevel[k] &&
					losTarget[k*3 +: 3] == MY_INDEX) begin
				hit = 1'b1;
			end
		end
	end

	// Pins are straps during reset, so no loss is honoured then
	always_ff @(posedge clk) begin
		if (srst) begin
			disqualified <= 1'b0;
		end else begin
			disqualified <= losLive && hit;
		end
	end

endmodule : rsp_ref_qualifier

// [tb/rsp_strap_sva.sv]
// Checker: port-level properties of the strap and pin-role block
`timescale 1ns/1ps
// ==========
module rsp_strap_sva #(
	parameter int NUM_CC = 2,
	parameter int NUM_DIFF = 5
) (
	// Clock, reset and APB
	input wire logic clk,
	input wire logic srst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// Pins and results
	input wire logic oscFreqStrap0,
	input wire logic oscFreqStrap1,
	input wire logic oscFreqStrap2,
	input wire logic rateFamilyStrap,
	input wire logic roleSelectPin,
	input wire logic [2:0] oscFreqSel,
	input wire logic rateFamilyBit,
	input wire logic isMaster,
	input wire logic [NUM_DIFF-1:0] diffSyncMode,
	input wire logic [NUM_DIFF-1:0] pairError,
	input wire logic [NUM_CC+NUM_DIFF-1:0] refDisqualified
);
	// Any loss line high; a read setup cycle
	wire anyLoss = oscFreqStrap0 | oscFreqStrap1 | oscFreqStrap2 |
		rateFamilyStrap;
	wire rdSetup = psel & !penable & !pwrite;
	default clocking @(posedge clk); endclocking
	default disable iff (srst);
	a_pready_high: assert property (pready) else $error("pready low");
	a_err_unmapped: assert property (psel && penable && paddr[1:0] == 2'b00
		|-> pslverr == (paddr > 8'h14)) else $error("pslverr wrong");
	a_freq_capture: assert property ($fell(srst) |-> oscFreqSel ==
		$past({oscFreqStrap2, oscFreqStrap1, oscFreqStrap0}))
		else $error("freq code not captured");
	a_rate_capture: assert property ($fell(srst) |->
		rateFamilyBit == $past(rateFamilyStrap)) else $error("rate bit wrong");
	a_straps_held: assert property (!$past(srst) |-> $stable(oscFreqSel))
		else $error("freq code moved");
	a_master_pin: assert property ($changed(roleSelectPin) && !$past(srst)
		&& !(psel && pwrite) && !$past(psel && pwrite)
		|=> isMaster != $past(isMaster)) else $error("role not followed");
	a_strap_read: assert property (rdSetup && paddr == 8'h00 |=>
		prdata[4] == $past(roleSelectPin) && prdata[2:0] == $past(oscFreqSel))
		else $error("strap readback wrong");
	a_qual_read: assert property (rdSetup && paddr == 8'h14 |=>
		prdata[8] == $past(isMaster)) else $error("master status wrong");
	a_disq_cause: assert property (!$past(anyLoss) |-> refDisqualified == '0)
		else $error("disqualified without loss");
	a_pair_sync: assert property (
		(pairError & ~$past(diffSyncMode)) == '0)
		else $error("pair error on clock input");
endmodule : rsp_strap_sva

bind rsp_reset_strap_pin_function rsp_strap_sva #(.NUM_CC(NUM_CC),
	.NUM_DIFF(NUM_DIFF)) rsp_strap_sva_i (.clk, .srst, .psel, .penable,
	.pwrite, .paddr, .prdata, .pready, .pslverr, .oscFreqStrap0,
	.oscFreqStrap1, .oscFreqStrap2, .rateFamilyStrap, .roleSelectPin,
	.oscFreqSel, .rateFamilyBit, .isMaster, .diffSyncMode, .pairError,
	.refDisqualified);

// [tb/rsp_board_straps.sv]
// Partner: board strap resistors and loss-of-signal sources on shared pins
`timescale 1ns/1ps
// ==========
module rsp_board_straps (
	// Phase and board settings
	input wire logic inReset,
	input wire logic [3:0] strapVal,
	input wire logic [3:0] lossVal,
	// Shared pins {rate, freq2, freq1, freq0}
	output logic [3:0] pins
);
	// Straps only show while reset holds; the loss sources own the pins after
	assign pins = inReset ? strapVal : lossVal;
endmodule : rsp_board_straps

// [tb/rsp_reset_strap_pin_function_tb.sv]
// Testbench: strap capture, loss routing, role select and reference roles
`timescale 1ns/1ps
// ==========
module rsp_reset_strap_pin_function_tb;
	import rsp_pkg::*;
	logic clk = 1'b0;
	logic srst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic roleSelectPin = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rd;
	logic pready, pslverr, er, rateFamilyBit, isMaster;
	logic [2:0] oscFreqSel;
	logic [1:0] ccFramePulseMode, cc400Present;
	logic [4:0] diffSyncMode, pairError;
	logic [9:0] diffSyncRate;
	logic [14:0] diffSyncPartner;
	logic [6:0] refDisqualified;
	logic [3:0] strapVal = 4'hD;
	logic [3:0] lossVal = 4'h0;
	logic [3:0] pins;
	logic [6:0] dq [4] = '{7'h04, 7'h40, 7'h02, 7'h01};
	int num_errors = 0;
	int tests_run = 0;

	always #10 clk = ~clk;

	rsp_board_straps rsp_board_straps_i (.inReset(srst), .strapVal, .lossVal,
		.pins);
	rsp_reset_strap_pin_function rsp_reset_strap_pin_function_i (.clk, .srst,
		.psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.oscFreqStrap0(pins[0]), .oscFreqStrap1(pins[1]),
		.oscFreqStrap2(pins[2]), .rateFamilyStrap(pins[3]), .roleSelectPin,
		.oscFreqSel, .rateFamilyBit, .isMaster, .ccFramePulseMode,
		.cc400Present, .diffSyncMode, .diffSyncRate, .diffSyncPartner,
		.pairError, .refDisqualified);

	// ==========
	task finish_test;
		$display("checks %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : finish_test

	task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	task tk(input int n);
		repeat (n) @(posedge clk);
	endtask : tk

	// One APB transfer; request held until pready is seen high
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1) begin
			num_errors++;
			finish_test();
		end else begin
			rd = prdata;
			er = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask : apb

	// Reset with given straps {rate, freq}, then check the capture
	task rst(input logic [3:0] s);
		srst <= 1'b1;
		strapVal <= s;
		tk(12);
		srst <= 1'b0;
		tk(1);
		chk("freq", s[2:0], oscFreqSel);
		chk("rate", s[3], rateFamilyBit);
	endtask : rst

	// ==========
	initial begin
		rst(4'hD);
		lossVal <= 4'hF;
		apb(1'b0, RSP_ADDR_STRAP, 32'h0);
		chk("strap", 32'h2D, rd & 32'h3F);
		chk("err", 32'h0, er);
		apb(1'b0, RSP_ADDR_CONFIG, 32'h0);
		chk("cfg", 32'h4, rd & 32'h5);
		chk("held", 32'h5, oscFreqSel);
		chk("unmapped loss", 32'h0, refDisqualified);
		$display("test straps done");
		// Lines a,b,c,d to refs 2,6,1,0
		lossVal <= 4'h0;
		apb(1'b1, RSP_ADDR_LOS_MAP, 32'h89EA);
		for (int i = 0; i < 4; i++) begin
			lossVal <= 4'h1 << i;
			tk(3);
			chk("disq", dq[i], refDisqualified);
		end
		apb(1'b0, RSP_ADDR_QUAL, 32'h0);
		chk("qual", 32'h8001, rd & 32'h1FF17F);
		lossVal <= 4'h0;
		$display("test loss done");
		roleSelectPin <= 1'b1;
		tk(2);
		chk("master", 32'h1, isMaster);
		apb(1'b0, RSP_ADDR_STRAP, 32'h0);
		chk("role pin", 32'h1, rd[4]);
		apb(1'b1, RSP_ADDR_CONFIG, 32'h5);
		tk(2);
		chk("slave", 32'h0, isMaster);
		roleSelectPin <= 1'b0;
		tk(2);
		chk("master", 32'h1, isMaster);
		$display("test role done");
		for (int r = 0; r < 4; r++) begin
			apb(1'b1, RSP_ADDR_REF_MODE, 32'h19 | (r << 12));
			tk(1);
			chk("sync rate", r, diffSyncRate[1:0]);
		end
		chk("cc modes", 32'h9, {cc400Present, ccFramePulseMode});
		chk("sync mode", 32'h1, diffSyncMode);
		apb(1'b1, RSP_ADDR_PAIR, 32'h3);
		tk(2);
		chk("pair ok", 32'h0, pairError);
		chk("partner", 32'h3, diffSyncPartner[2:0]);
		apb(1'b1, RSP_ADDR_PAIR, 32'h2);
		tk(2);
		chk("pair self", 32'h1, pairError);
		$display("test refs done");
		apb(1'b1, 8'h20, 32'hFFFFFFFF);
		chk("err", 32'h1, er);
		apb(1'b0, 8'h20, 32'h0);
		chk("unmapped", 32'h0, rd);
		chk("err", 32'h1, er);
		rst(4'h2);
		apb(1'b0, RSP_ADDR_CONFIG, 32'h0);
		chk("cfg", 32'h0, rd & 32'h5);
		$display("test rerun done");
		finish_test();
	end
endmodule : rsp_reset_strap_pin_function_tb
